// ---- core/flash_front_end.sv ----
// Serial interface front end of a serial flash: lanes, pause, write guard.
// Assumes the serial clock runs well below clk_sys/6 and the array side
// reacts on clk_sys with op_start, op_done, prog and fill strobes.
`timescale 1ns/10ps
// Behaviour
// (RULE1) Single lane: instruction, address, data sampled on serial clock rise.
// (RULE2) Single lane: read data and status driven on lane one at clock fall.
// (RULE3) Clock modes 0 and 3 both work; idle clock level is the host's.
// (RULE4) Dual reads turn lanes zero and one into two-way data lanes.
// (RULE5) Quad reads use four lanes; guard and pause pins become lanes two/three.
// (RULE6) Four-lane instructions are ignored while four-lane enable is clear.
// (RULE7) Pause works only when selected and not in four-lane transfers.
// (RULE8) Pause starts at pause pin fall if clock low, else after next fall.
// (RULE9) Pause ends at pause pin rise if clock low, else after next fall.
// (RULE10) Paused: outputs float, clock and input ignored, state is kept.
// (RULE11) Host keeps select low while paused; deselect aborts the instruction.
// (RULE12) Under reset nothing runs and no instruction is recognised.
// (RULE13) After reset, write-class instructions are rejected for a fixed delay.
// (RULE14) After reset the write-arm latch is clear.
// (RULE15) Program, erase and status write need the write-arm latch set.
// (RULE16) Write-arm latch clears on write disable and on operation completion.
// (RULE17) In power-down only the release instruction is recognised.
// (RULE18) Status write depends on lock select, write-arm latch and guard pin.
// (RULE19) Busy bit S0 is set during operations and clears on completion.
// (RULE20) While busy only status reads and suspend are accepted.
// (RULE21) Write-arm latch is read-only bit S1, set by write enable.
// (RULE22) Region guard bits S4..S2 are written by status write, reset to 0.
// (RULE23) Deselected lanes float; first instruction needs a select fall.
// (RULE24) Four-lane enable is S9; it disables guard and pause pin use.
// (RULE25) Lock select: 00 none, 01 guard pin, 10 until reset, 11 forever; code clears 11 at reset like 10.
// (RULE26) All bytes are shifted most significant bit first.
module flash_front_end #(
	parameter int unsigned PUW_CYCLES = flash_pkg::POWERUP_WRITE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic spi_clk,
	input wire logic sel_n,
	input wire logic lane_zero_in,
	output logic lane_zero_out,
	output logic lane_zero_oe,
	input wire logic lane_one_in,
	output logic lane_one_out,
	output logic lane_one_oe,
	input wire logic lane_two_in,
	output logic lane_two_out,
	output logic lane_two_oe,
	input wire logic lane_three_in,
	output logic lane_three_out,
	output logic lane_three_oe,
	output logic op_start,
	output logic [7:0] op_code,
	output logic [23:0] op_addr,
	input wire logic op_done,
	output logic op_suspend,
	output logic prog_valid,
	output logic [7:0] prog_data,
	output logic rd_req,
	output logic [23:0] rd_addr,
	input wire logic [7:0] fill_data,
	input wire logic fill_valid,
	output logic fill_ready,
	output logic [15:0] status_word,
	output logic power_down
);
	logic [5:0] pins_s;
	logic sclk_s, seln_s;
	logic [3:0] lane_s;
	logic sclk_d_r, sel_d_r, armed_r, sel_act, sel_rise;
	logic rise_ok, fall_ok, paused_r, hold_en;
	flash_pkg::xfer_state_e state_r;
	flash_pkg::op_kind_e kind;
	logic [7:0] op_r, in_sr_r, shift_nxt, dec_op;
	logic [2:0] bit_cnt_r, lanes_r, a_l, d_l, obit_cnt_r;
	logic [3:0] bit_sum, dummy_r, dum, drv_r, oe_r;
	logic byte_done, quad, wcls, acc, quad_xfer_r;
	logic [1:0] byte_cnt_r, n_data_r;
	logic [23:0] addr_r;
	logic [15:0] wrsr_r, nv_r, wr_val;
	logic busy_r, wel_r, pd_r, qe, sw_ok, pu_hold, end_ok;
	logic [31:0] pu_cnt_r;
	logic [7:0] cur, out_sr_r, out_nxt, new_byte;
	logic [3:0] drv_nxt;
	logic drain_take;

	byte_stream_if fill_if();
	byte_stream_if drain_if();

	pin_sync #(.W(6)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d_in({spi_clk, sel_n, lane_three_in, lane_two_in, lane_one_in,
			lane_zero_in}),
		.q(pins_s)
	);

	two_entry_buffer u_buf (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.flush(sel_rise),
		.fill(fill_if.snk),
		.drain(drain_if.src)
	);

	assign fill_if.data = fill_data;
	assign fill_if.valid = fill_valid;
	assign fill_ready = fill_if.ready;
	assign drain_if.ready = drain_take;

	assign sclk_s = pins_s[5];
	assign seln_s = pins_s[4];
	assign lane_s = pins_s[3:0];
	assign qe = nv_r[flash_pkg::FOUR_LANE_BIT];
	assign sel_act = armed_r & ~seln_s; // see (RULE23)
	assign sel_rise = seln_s & ~sel_d_r;
	assign hold_en = ~qe & ~quad_xfer_r; // see (RULE7) see (RULE24)
	assign rise_ok = sel_act & ~paused_r & sclk_s & ~sclk_d_r; // see (RULE10)
	assign fall_ok = sel_act & ~paused_r & ~sclk_s & sclk_d_r;
	assign pu_hold = (pu_cnt_r != PUW_CYCLES);
	assign status_word = {nv_r[15:2], wel_r, busy_r}; // see (RULE19) see (RULE21)
	assign power_down = pd_r;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sclk_d_r <= 1'b0;
			sel_d_r <= 1'b1;
			armed_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
			sel_d_r <= seln_s;
			if (seln_s) begin
				armed_r <= 1'b1; // see (RULE23)
			end
		end
	end

	// Pin only steers the pause while the clock sits low
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !sel_act || !hold_en) begin
			paused_r <= 1'b0; // see (RULE11)
		end else if (!sclk_s) begin
			paused_r <= ~lane_s[3]; // see (RULE8) see (RULE9)
		end
	end

	// Long count kept as a parameter so a bench can shorten it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pu_cnt_r <= 32'h0;
		end else if (pu_hold) begin
			pu_cnt_r <= pu_cnt_r + 32'h1; // see (RULE13)
		end
	end

	assign dec_op = (state_r == flash_pkg::ST_CMD) ? shift_nxt : op_r;
	assign bit_sum = {1'b0, bit_cnt_r} + {1'b0, lanes_r};
	assign byte_done = bit_sum[3];

	always_comb begin
		case (lanes_r)
			3'd2: shift_nxt = {in_sr_r[5:0], lane_s[1:0]};
			3'd4: shift_nxt = {in_sr_r[3:0], lane_s}; // see (RULE5)
			default: shift_nxt = {in_sr_r[6:0], lane_s[0]}; // see (RULE1)
		endcase
	end

	always_comb begin
		kind = flash_pkg::KIND_BAD;
		a_l = 3'd1;
		d_l = 3'd1;
		dum = 4'h0;
		quad = 1'b0;
		wcls = 1'b0;
		case (dec_op)
			flash_pkg::OP_RDSR1, flash_pkg::OP_RDSR2: begin
				kind = flash_pkg::KIND_STATUS;
			end
			flash_pkg::OP_READ: begin
				kind = flash_pkg::KIND_READ;
			end
			flash_pkg::OP_FAST: begin
				kind = flash_pkg::KIND_READ;
				dum = flash_pkg::DUMMY_FAST;
			end
			flash_pkg::OP_DUAL_OUT: begin
				kind = flash_pkg::KIND_READ;
				dum = flash_pkg::DUMMY_FAST;
				d_l = 3'd2; // see (RULE4)
			end
			flash_pkg::OP_DUAL_IO: begin
				kind = flash_pkg::KIND_READ;
				dum = flash_pkg::DUMMY_DUAL_IO;
				a_l = 3'd2; // see (RULE4)
				d_l = 3'd2;
			end
			flash_pkg::OP_QUAD_OUT: begin
				kind = flash_pkg::KIND_READ;
				dum = flash_pkg::DUMMY_FAST;
				d_l = 3'd4; // see (RULE5)
				quad = 1'b1;
			end
			flash_pkg::OP_QUAD_IO, flash_pkg::OP_WORD_QIO,
			flash_pkg::OP_OCTAL_QIO: begin
				kind = flash_pkg::KIND_READ;
				a_l = 3'd4; // see (RULE5)
				d_l = 3'd4;
				quad = 1'b1;
				if (dec_op == flash_pkg::OP_QUAD_IO) begin
					dum = flash_pkg::DUMMY_QUAD_IO;
				end else if (dec_op == flash_pkg::OP_WORD_QIO) begin
					dum = flash_pkg::DUMMY_WORD_QIO;
				end else begin
					dum = flash_pkg::DUMMY_OCTAL_QIO;
				end
			end
			flash_pkg::OP_PROG: begin
				kind = flash_pkg::KIND_PROG;
				wcls = 1'b1;
			end
			flash_pkg::OP_QPROG: begin
				kind = flash_pkg::KIND_PROG;
				d_l = 3'd4;
				quad = 1'b1;
				wcls = 1'b1;
			end
			flash_pkg::OP_SE, flash_pkg::OP_BE32, flash_pkg::OP_BE64: begin
				kind = flash_pkg::KIND_ERASE;
				wcls = 1'b1;
			end
			flash_pkg::OP_CE1, flash_pkg::OP_CE2, flash_pkg::OP_WREN: begin
				kind = flash_pkg::KIND_BARE;
				wcls = 1'b1;
			end
			flash_pkg::OP_WRDI, flash_pkg::OP_PD, flash_pkg::OP_REL,
			flash_pkg::OP_SUSPEND: begin
				kind = flash_pkg::KIND_BARE;
			end
			flash_pkg::OP_WRSR: begin
				kind = flash_pkg::KIND_WRSR;
				wcls = 1'b1;
			end
			default: begin
				kind = flash_pkg::KIND_BAD;
			end
		endcase
	end

	always_comb begin
		acc = (kind != flash_pkg::KIND_BAD);
		if (pd_r) begin
			acc = (dec_op == flash_pkg::OP_REL); // see (RULE17)
		end else if (busy_r) begin
			acc = (dec_op == flash_pkg::OP_RDSR1) || // see (RULE20)
				(dec_op == flash_pkg::OP_RDSR2) ||
				(dec_op == flash_pkg::OP_SUSPEND);
		end
		if (quad && !qe) begin
			acc = 1'b0; // see (RULE6)
		end
		if (wcls && pu_hold) begin
			acc = 1'b0; // see (RULE13)
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst || !sel_act) begin
			state_r <= flash_pkg::ST_IDLE; // see (RULE12)
			op_r <= 8'h00;
			in_sr_r <= 8'h00;
			bit_cnt_r <= 3'd0;
			lanes_r <= 3'd1;
			byte_cnt_r <= 2'd0;
			n_data_r <= 2'd0;
			dummy_r <= 4'h0;
			addr_r <= 24'h0;
			wrsr_r <= 16'h0;
			quad_xfer_r <= 1'b0;
		end else if (state_r == flash_pkg::ST_IDLE) begin
			state_r <= flash_pkg::ST_CMD;
		end else if (rise_ok) begin
			in_sr_r <= shift_nxt; // see (RULE26)
			bit_cnt_r <= bit_sum[2:0];
			case (state_r)
				flash_pkg::ST_CMD: begin
					if (byte_done && !acc) begin
						state_r <= flash_pkg::ST_IGNORE;
					end else if (byte_done) begin
						op_r <= shift_nxt;
						quad_xfer_r <= quad;
						if (kind == flash_pkg::KIND_STATUS) begin
							state_r <= flash_pkg::ST_RDATA;
						end else if (kind == flash_pkg::KIND_BARE ||
							kind == flash_pkg::KIND_WRSR) begin
							state_r <= flash_pkg::ST_WDATA;
						end else begin
							state_r <= flash_pkg::ST_ADDR;
							lanes_r <= a_l;
						end
					end
				end
				flash_pkg::ST_ADDR: begin
					if (byte_done) begin
						addr_r <= {addr_r[15:0], shift_nxt};
						byte_cnt_r <= byte_cnt_r + 2'd1;
						if (byte_cnt_r == 2'd2) begin
							dummy_r <= dum;
							if (kind == flash_pkg::KIND_ERASE) begin
								state_r <= flash_pkg::ST_WDATA;
								lanes_r <= 3'd1;
							end else if (dum != 4'h0) begin
								state_r <= flash_pkg::ST_DUMMY;
							end else begin
								state_r <= (kind == flash_pkg::KIND_PROG) ?
									flash_pkg::ST_WDATA : flash_pkg::ST_RDATA;
								lanes_r <= d_l;
							end
						end
					end
				end
				flash_pkg::ST_DUMMY: begin
					dummy_r <= dummy_r - 4'h1;
					bit_cnt_r <= 3'd0;
					if (dummy_r == 4'h1) begin
						state_r <= flash_pkg::ST_RDATA;
						lanes_r <= d_l;
					end
				end
				flash_pkg::ST_WDATA: begin
					if (byte_done) begin
						if (n_data_r == 2'd0) begin
							wrsr_r[7:0] <= shift_nxt;
						end else if (n_data_r == 2'd1) begin
							wrsr_r[15:8] <= shift_nxt;
						end
						if (n_data_r != 2'd3) begin
							n_data_r <= n_data_r + 2'd1;
						end
					end
				end
				default: begin
					state_r <= state_r;
				end
			endcase
		end
	end

	// Read-back stream; an empty buffer shifts out ones rather than stalling
	assign new_byte = (kind == flash_pkg::KIND_STATUS) ?
		((op_r == flash_pkg::OP_RDSR2) ? status_word[15:8] : status_word[7:0]) :
		(drain_if.valid ? drain_if.data : flash_pkg::EMPTY_BYTE);
	assign cur = (obit_cnt_r == 3'd0) ? new_byte : out_sr_r;
	assign drain_take = fall_ok && (state_r == flash_pkg::ST_RDATA) &&
		(obit_cnt_r == 3'd0) && (kind != flash_pkg::KIND_STATUS);

	always_comb begin
		drv_nxt = drv_r;
		case (lanes_r)
			3'd2: begin
				drv_nxt[1:0] = cur[7:6]; // see (RULE4)
				out_nxt = {cur[5:0], 2'b00};
			end
			3'd4: begin
				drv_nxt = cur[7:4]; // see (RULE5)
				out_nxt = {cur[3:0], 4'h0};
			end
			default: begin
				drv_nxt[1] = cur[7]; // see (RULE2)
				out_nxt = {cur[6:0], 1'b0};
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			obit_cnt_r <= 3'd0;
			out_sr_r <= 8'h00;
			drv_r <= 4'h0;
		end else if (state_r != flash_pkg::ST_RDATA) begin
			obit_cnt_r <= 3'd0;
		end else if (fall_ok) begin
			drv_r <= drv_nxt; // see (RULE2) see (RULE3)
			out_sr_r <= out_nxt;
			obit_cnt_r <= obit_cnt_r + lanes_r;
		end
	end

	// Enables fall on deselect and pause, so lanes float in both
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !sel_act || paused_r ||
			state_r != flash_pkg::ST_RDATA) begin
			oe_r <= 4'h0; // see (RULE10) see (RULE23)
		end else begin
			case (lanes_r)
				3'd2: oe_r <= 4'h3;
				3'd4: oe_r <= 4'hf;
				default: oe_r <= 4'h2;
			endcase
		end
	end

	assign lane_zero_out = drv_r[0];
	assign lane_one_out = drv_r[1];
	assign lane_two_out = drv_r[2];
	assign lane_three_out = drv_r[3];
	assign lane_zero_oe = oe_r[0];
	assign lane_one_oe = oe_r[1];
	assign lane_two_oe = oe_r[2];
	assign lane_three_oe = oe_r[3];

	// Write guard: when four-lane is on, the guard pin reads as high
	always_comb begin
		case ({nv_r[flash_pkg::LOCK_HI_BIT], nv_r[flash_pkg::LOCK_LO_BIT]})
			2'b00: sw_ok = 1'b1; // see (RULE25)
			2'b01: sw_ok = qe | lane_s[2]; // see (RULE18)
			default: sw_ok = 1'b0;
		endcase
	end

	assign end_ok = sel_rise && !paused_r && (state_r == flash_pkg::ST_WDATA) &&
		(bit_cnt_r == 3'd0);
	assign wr_val = (n_data_r == 2'd1) ? {nv_r[15:8], wrsr_r[7:0]} : wrsr_r;

	always_ff @(posedge clk_sys) begin
		op_start <= 1'b0;
		op_suspend <= 1'b0;
		if (sys_rst) begin
			busy_r <= 1'b0;
			wel_r <= 1'b0; // see (RULE14)
			pd_r <= 1'b0;
			nv_r <= flash_pkg::STATUS_RESET; // see (RULE22)
			op_code <= 8'h00;
			op_addr <= 24'h0;
		end else if (busy_r && op_done) begin
			busy_r <= 1'b0; // see (RULE19)
			wel_r <= 1'b0; // see (RULE16)
		end else if (end_ok) begin
			op_code <= op_r;
			op_addr <= addr_r;
			case (kind)
				flash_pkg::KIND_BARE: begin
					if (n_data_r == 2'd0) begin
						if (op_r == flash_pkg::OP_WREN) begin
							wel_r <= 1'b1; // see (RULE21)
						end else if (op_r == flash_pkg::OP_WRDI) begin
							wel_r <= 1'b0; // see (RULE16)
						end else if (op_r == flash_pkg::OP_PD) begin
							pd_r <= 1'b1;
						end else if (op_r == flash_pkg::OP_REL) begin
							pd_r <= 1'b0;
						end else if (op_r == flash_pkg::OP_SUSPEND) begin
							op_suspend <= 1'b1;
						end else if (wel_r) begin
							busy_r <= 1'b1; // see (RULE15)
							op_start <= 1'b1;
						end
					end
				end
				flash_pkg::KIND_ERASE: begin
					if (n_data_r == 2'd0 && wel_r) begin
						busy_r <= 1'b1; // see (RULE15)
						op_start <= 1'b1;
					end
				end
				flash_pkg::KIND_PROG: begin
					if (n_data_r != 2'd0 && wel_r) begin
						busy_r <= 1'b1; // see (RULE15)
						op_start <= 1'b1;
					end
				end
				flash_pkg::KIND_WRSR: begin
					if (n_data_r != 2'd0 && wel_r && sw_ok) begin
						nv_r <= (wr_val & flash_pkg::STATUS_WR_MASK) |
							(nv_r & flash_pkg::STATUS_OTP_MASK); // see (RULE22)
						busy_r <= 1'b1; // see (RULE18)
						op_start <= 1'b1;
					end
				end
				default: begin
					busy_r <= busy_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prog_valid <= 1'b0;
			prog_data <= 8'h00;
			rd_req <= 1'b0;
			rd_addr <= 24'h0;
		end else begin
			prog_valid <= rise_ok && byte_done && wel_r &&
				(state_r == flash_pkg::ST_WDATA) &&
				(kind == flash_pkg::KIND_PROG);
			rd_req <= rise_ok && byte_done && (byte_cnt_r == 2'd2) &&
				(state_r == flash_pkg::ST_ADDR) &&
				(kind == flash_pkg::KIND_READ);
			if (rise_ok && byte_done) begin
				prog_data <= shift_nxt;
				if (state_r == flash_pkg::ST_ADDR) begin
					rd_addr <= {addr_r[15:0], shift_nxt};
				end
			end
		end
	end
endmodule

// ---- core/flash_pkg.sv ----
// Constants, opcodes, status layout and states of the serial flash front end.
// Assumes a 40 MHz system clock that oversamples the serial clock.
package flash_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR = 3'b010,
		ST_DUMMY = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_IGNORE = 3'b110
	} xfer_state_e;

	typedef enum logic [2:0] {
		KIND_BAD = 3'b000,
		KIND_STATUS = 3'b001,
		KIND_READ = 3'b010,
		KIND_PROG = 3'b011,
		KIND_ERASE = 3'b100,
		KIND_BARE = 3'b101,
		KIND_WRSR = 3'b110
	} op_kind_e;

	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;
	localparam logic [7:0] OP_WORD_QIO = 8'he7;
	localparam logic [7:0] OP_OCTAL_QIO = 8'he3;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_QPROG = 8'h32;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hd8;
	localparam logic [7:0] OP_CE1 = 8'hc7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	localparam logic [7:0] OP_PD = 8'hb9;
	localparam logic [7:0] OP_REL = 8'hab;
	localparam logic [7:0] OP_SUSPEND = 8'h75;

	localparam logic [3:0] DUMMY_FAST = 4'h8;
	localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
	localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
	localparam logic [3:0] DUMMY_WORD_QIO = 4'h4;
	localparam logic [3:0] DUMMY_OCTAL_QIO = 4'h2;

	localparam int BUSY_BIT = 0;
	localparam int WRITE_ARM_BIT = 1;
	localparam int LOCK_LO_BIT = 7;
	localparam int LOCK_HI_BIT = 8;
	localparam int FOUR_LANE_BIT = 9;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] STATUS_WR_MASK = 16'h7bfc;
	localparam logic [15:0] STATUS_OTP_MASK = 16'h3800;
	localparam logic [7:0] EMPTY_BYTE = 8'hff;

	localparam int CLK_MHZ = 40;
	localparam int POWERUP_WRITE_DELAY_US = 1000;
	localparam int POWERUP_WRITE_CYCLES = POWERUP_WRITE_DELAY_US * CLK_MHZ;

endpackage

// ---- core/byte_stream_if.sv ----
// Byte stream with valid and ready between the front end's own modules.
// Assumes both ends run on clk_sys.
`timescale 1ns/10ps
interface byte_stream_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

// ---- core/pin_sync.sv ----
// Two-flop synchroniser per bit for the serial pins.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 6
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					meta_r[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta_r[i] <= d_in[i];
					q[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule

// ---- core/two_entry_buffer.sv ----
// Two-entry byte buffer between the array read port and the output shifter.
// Assumes flush is a one-cycle pulse on clk_sys.
`timescale 1ns/10ps
module two_entry_buffer (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic flush,
	byte_stream_if.snk fill,
	byte_stream_if.src drain
);
	logic [7:0] mem_r [2];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] count_r;
	logic push;
	logic pop;

	assign fill.ready = (count_r != 2'd2);
	assign drain.valid = (count_r != 2'd0);
	assign drain.data = mem_r[rd_ptr_r];
	assign push = fill.valid & fill.ready;
	assign pop = drain.valid & drain.ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wr_ptr_r] <= fill.data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst || flush) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'd0;
		end else begin
			if (push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// ---- tb/spi_host_model.sv ----
// SPI host stand-in: drives clock, select and lane zero, reads lane one.
// Assumes clk_sys at 40 MHz; serial clock half period of four cycles.
`timescale 1ns/10ps
module spi_host_model (
	input wire logic clk_sys,
	input wire logic lane_one_out,
	input wire logic lane_one_oe,
	output logic spi_clk,
	output logic sel_n,
	output logic lane_zero_in,
	output logic lane_one_in,
	output logic drove
);
	logic cpol;
	logic float_r;
	initial begin
		spi_clk = 1'b0;
		sel_n = 1'b1;
		lane_zero_in = 1'b0;
		float_r = 1'b0;
		cpol = 1'b0;
		drove = 1'b0;
	end
	// Released line toggles so a stale bit never looks driven
	always @(posedge clk_sys) begin
		float_r <= ~float_r;
		if (lane_one_oe)
			drove <= 1'b1;
	end
	assign lane_one_in = lane_one_oe ? lane_one_out : float_r;
	task automatic go(input logic mode3);
		cpol = mode3;
		@(posedge clk_sys);
		spi_clk <= mode3;
		repeat (4) @(posedge clk_sys);
		sel_n <= 1'b0;
		drove <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic xb(input logic [7:0] b, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			spi_clk <= 1'b0;
			lane_zero_in <= b[i];
			repeat (4) @(posedge clk_sys);
			spi_clk <= 1'b1;
			@(posedge clk_sys);
			q[i] = lane_one_in;
			repeat (3) @(posedge clk_sys);
		end
	endtask
	task automatic stop();
		spi_clk <= cpol;
		repeat (4) @(posedge clk_sys);
		sel_n <= 1'b1;
		repeat (12) @(posedge clk_sys);
	endtask
endmodule

// ---- tb/flash_front_end_checker.sv ----
// Port checker for the front end: reset, busy, write arm, lanes.
// Assumes it is bound to every front end instance.
`timescale 1ns/10ps
module flash_front_end_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sel_n,
	input wire logic lane_zero_oe,
	input wire logic lane_one_oe,
	input wire logic lane_three_oe,
	input wire logic op_start,
	input wire logic op_done,
	input wire logic prog_valid,
	input wire logic rd_req,
	input wire logic [15:0] status_word,
	input wire logic power_down
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	property p_rst_quiet;
		disable iff (1'b0) sys_rst |=> !lane_one_oe && !op_start
			&& status_word == 16'h0000;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("active in reset");
	// Sync (two flops) plus enable register delay is three cycles, so six high samples are safe
	property p_float;
		sel_n [*6] |-> !lane_zero_oe && !lane_one_oe && !lane_three_oe;
	endproperty
	a_float: assert property (p_float)
		else $error("lane driven while deselected");
	property p_busy_set;
		op_start |-> ##[0:2] status_word[0];
	endproperty
	a_busy_set: assert property (p_busy_set)
		else $error("busy not set");
	property p_done_clr;
		op_done |-> ##[1:2] status_word[1:0] == 2'b00;
	endproperty
	a_done_clr: assert property (p_done_clr)
		else $error("busy or arm kept");
	property p_busy_hold;
		$fell(status_word[0]) |-> $past(op_done) || $past(op_done, 2);
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy dropped early");
	property p_armed;
		op_start || prog_valid |-> status_word[1];
	endproperty
	a_armed: assert property (p_armed)
		else $error("write while unarmed");
	property p_quad;
		lane_three_oe |-> status_word[9];
	endproperty
	a_quad: assert property (p_quad)
		else $error("four lanes while disabled");
	property p_sleep;
		power_down |-> !op_start && !rd_req && !lane_one_oe;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("activity in power-down");
	property p_arm_end;
		$rose(status_word[1]) |-> sel_n;
	endproperty
	a_arm_end: assert property (p_arm_end)
		else $error("arm set mid-frame");
endmodule
bind flash_front_end flash_front_end_checker chk (.clk_sys, .sys_rst,
	.sel_n, .lane_zero_oe, .lane_one_oe, .lane_three_oe, .op_start,
	.op_done, .prog_valid, .rd_req, .status_word, .power_down);

// ---- tb/test_flash_front_end.sv ----
// Bench for the flash front end with host and array stand-ins.
// Assumes the checker binds itself; array ops last 600 cycles.
`timescale 1ns/10ps
module test_flash_front_end;
	logic clk_sys, sys_rst, spi_clk, sel_n, lane_zero_in, lane_one_in;
	logic lane_one_out, lane_one_oe, lane_two_in, lane_three_in, drove;
	logic op_start, op_done, prog_valid, rd_req, fill_valid, fill_ready;
	logic power_down;
	logic [7:0] op_code, prog_data, fill_data, r, s, pd_last, oc, d;
	logic [23:0] op_addr, rd_addr, a, oa;
	logic [15:0] status_word;
	int n_errors, check_count, seed, cyc, bc, n_rd, n_op;
	spi_host_model host (.clk_sys, .lane_one_out, .lane_one_oe, .spi_clk,
		.sel_n, .lane_zero_in, .lane_one_in, .drove);
	flash_front_end #(.PUW_CYCLES(400)) DUT (.clk_sys, .sys_rst, .spi_clk,
		.sel_n, .lane_zero_in, .lane_zero_out(), .lane_zero_oe(),
		.lane_one_in, .lane_one_out, .lane_one_oe, .lane_two_in,
		.lane_two_out(), .lane_two_oe(), .lane_three_in,
		.lane_three_out(), .lane_three_oe(), .op_start, .op_code,
		.op_addr, .op_done, .op_suspend(), .prog_valid, .prog_data,
		.rd_req, .rd_addr, .fill_data, .fill_valid, .fill_ready,
		.status_word, .power_down);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic logic [23:0] sr1(input logic write_arm_latch, input logic busy);
		return {22'h0, write_arm_latch, busy};
	endfunction
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic done(input string n);
		$display("test %s ends, mismatches %0d", n, n_errors);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op, input int nb);
		host.go(1'b0);
		host.xb(op, r);
		for (int k = nb - 1; k >= 0; k--)
			host.xb(a[k*8+:8], r);
		if (nb > 0 || op == flash_pkg::OP_WRSR)
			host.xb(d, s);
		host.stop();
	endtask
	task automatic rdsr(input logic m3);
		host.go(m3);
		host.xb(flash_pkg::OP_RDSR1, r);
		host.xb(8'h00, s);
		host.stop();
	endtask
	// Array stand-in; valid waits for a read so no stale byte is queued
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		fill_valid <= !sys_rst && (rd_req || (fill_valid && !sel_n));
		op_done <= bc == 1;
		bc <= op_start ? 600 : (bc > 0 ? bc - 1 : 0);
		n_rd <= n_rd + int'(rd_req);
		n_op <= n_op + int'(op_start);
		if (op_start) begin
			oa <= op_addr;
			oc <= op_code;
		end
		if (prog_valid)
			pd_last <= prog_data;
		if (rd_req)
			fill_data <= rd_addr[7:0];
		else if (fill_valid && fill_ready)
			fill_data <= fill_data + 8'h01;
		// Last in the process, so nothing runs after the report
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		sys_rst = 1'b1;
		lane_two_in = 1'b1;
		lane_three_in = 1'b1;
		op_done = 1'b0;
		fill_valid = 1'b0;
		fill_data = 8'h00;
		seed = 32'h64f8;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		cmd(flash_pkg::OP_WREN, 0);
		rdsr(1'b0);
		cmp(s, sr1(1'b0, 1'b0));
		repeat (200) @(posedge clk_sys);
		cmd(flash_pkg::OP_WREN, 0);
		rdsr(1'b1);
		cmp(s, sr1(1'b1, 1'b0));
		cmd(flash_pkg::OP_WRDI, 0);
		rdsr(1'b0);
		cmp(s, sr1(1'b0, 1'b0));
		d = 8'h1c;
		cmd(flash_pkg::OP_WRSR, 0);
		cmp(n_op, 0);
		done("arm");
		a = 24'($random(seed));
		d = 8'($random(seed));
		cmd(flash_pkg::OP_WREN, 0);
		cmd(flash_pkg::OP_PROG, 3);
		cmp(pd_last, d);
		cmp(oa, a);
		cmp(oc, flash_pkg::OP_PROG);
		cmd(flash_pkg::OP_WRDI, 0);
		rdsr(1'b0);
		cmp(s, sr1(1'b1, 1'b1));
		repeat (600) @(posedge clk_sys);
		rdsr(1'b0);
		cmp(s, sr1(1'b0, 1'b0));
		done("program");
		d = 8'h1c;
		cmd(flash_pkg::OP_WREN, 0);
		cmd(flash_pkg::OP_WRSR, 0);
		cmp(oc, flash_pkg::OP_WRSR);
		repeat (600) @(posedge clk_sys);
		rdsr(1'b0);
		cmp(s, 8'h1c);
		done("status write");
		a = 24'($random(seed));
		d = 8'h00;
		host.go(1'b0);
		host.xb(flash_pkg::OP_READ, r);
		for (int k = 2; k >= 0; k--)
			host.xb(a[k*8+:8], r);
		host.xb(8'h00, s);
		host.xb(8'h00, r);
		host.stop();
		cmp(rd_addr, a);
		cmp(s, a[7:0]);
		cmp(r, a[7:0] + 8'h01);
		cmd(flash_pkg::OP_QUAD_OUT, 3);
		cmp(n_rd, 1);
		cmp(drove, 1'b0);
		done("read");
		cmd(flash_pkg::OP_PD, 0);
		cmp(power_down, 1'b1);
		rdsr(1'b0);
		cmp(drove, 1'b0);
		cmd(flash_pkg::OP_REL, 0);
		cmp(power_down, 1'b0);
		done("sleep");
		host.go(1'b0);
		lane_three_in <= 1'b0;
		repeat (4) @(posedge clk_sys);
		host.xb(8'hff, r);
		lane_three_in <= 1'b1;
		host.xb(flash_pkg::OP_RDSR1, r);
		host.xb(8'h00, s);
		host.stop();
		cmp(s, 8'h1c);
		done("pause");
		wrap_up();
	end
endmodule
